// >>> rtl/hrbp_regs.vh
`ifndef HRBP_REGS_VH
`define HRBP_REGS_VH

// ****************************************************************
// Port widths and reset values.
// ****************************************************************
`define HRBP_ADDR_W 5
`define HRBP_DATA_W 8
`define HRBP_ZERO_ADDR 5'h00
`define HRBP_ZERO_DATA 8'h00
`define HRBP_RST_MIN_CLOCKS 5

// ****************************************************************
// Host pin vector layout and idle level.
// ****************************************************************
`define HRBP_PIN_CS 2
`define HRBP_PIN_DS 1
`define HRBP_PIN_WR 0
`define HRBP_PIN_IDLE 3'h7

`endif

// >>> rtl/hrbp_host_port.v
`timescale 1ns/1ps
`include "hrbp_regs.vh"

module hrbp_host_port #(
  parameter ADDR_W = `HRBP_ADDR_W,
  parameter DATA_W = `HRBP_DATA_W
) (
  // Clock and reset.
  input wire SYS_CLK,
  input wire RST_B,
  // Host bus pins.
  input wire CHIP_SELECT_LOW,
  input wire DATA_OR_READ_STROBE_LOW,
  input wire DIRECTION_OR_WRITE_STROBE_LOW,
  input wire [ADDR_W-1:0] ADDR,
  input wire [DATA_W-1:0] DATA_IN,
  output reg [DATA_W-1:0] DATA_OUT,
  output reg DATA_OE,
  output reg TRANSFER_ACKNOWLEDGE_LOW,
  output reg TRANSFER_ACKNOWLEDGE_OE,
  // Register file side.
  output reg REG_WR,
  output reg REG_RD,
  output reg [ADDR_W-1:0] REG_ADDR,
  output reg [DATA_W-1:0] REG_WDATA,
  input wire [DATA_W-1:0] REG_RDATA
);

  // ****************************************************************
  // States.
  // ****************************************************************
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_READ = 3'h2;
  localparam [2:0] ST_WRITE = 3'h4;

  // ****************************************************************
  // Request decoding.
  // ****************************************************************
  // A read needs chip select and data strobe low with the write strobe high.
  function read_req(input [2:0] pins);
    read_req = !pins[`HRBP_PIN_CS] && !pins[`HRBP_PIN_DS] && pins[`HRBP_PIN_WR];
  endfunction

  // A write needs chip select and the write strobe low.
  function write_req(input [2:0] pins);
    write_req = !pins[`HRBP_PIN_CS] && !pins[`HRBP_PIN_WR];
  endfunction

  // ****************************************************************
  // Reset synchroniser.
  // ****************************************************************
  reg rst_meta_q;
  reg rst_sync_q;
  wire rst_n;

  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  // ****************************************************************
  // Strobe synchronisers and bus sampling.
  // ****************************************************************
  reg [2:0] pin_meta_q;
  reg [2:0] pin_sync_q;
  reg [ADDR_W-1:0] addr_meta_q;
  reg [ADDR_W-1:0] addr_sync_q;
  reg [DATA_W-1:0] data_meta_q;
  reg [DATA_W-1:0] data_sync_q;
  wire cs_act;
  wire ds_act;
  wire wr_act;

  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= `HRBP_PIN_IDLE;
      pin_sync_q <= `HRBP_PIN_IDLE;
      addr_meta_q <= `HRBP_ZERO_ADDR;
      addr_sync_q <= `HRBP_ZERO_ADDR;
      data_meta_q <= `HRBP_ZERO_DATA;
      data_sync_q <= `HRBP_ZERO_DATA;
    end else begin
      pin_meta_q <= {CHIP_SELECT_LOW, DATA_OR_READ_STROBE_LOW,
                     DIRECTION_OR_WRITE_STROBE_LOW};
      pin_sync_q <= pin_meta_q;
      addr_meta_q <= ADDR;
      addr_sync_q <= addr_meta_q;
      data_meta_q <= DATA_IN;
      data_sync_q <= data_meta_q;
    end
  end

  assign cs_act = ~pin_sync_q[`HRBP_PIN_CS];
  assign ds_act = ~pin_sync_q[`HRBP_PIN_DS];
  assign wr_act = ~pin_sync_q[`HRBP_PIN_WR];

  // ****************************************************************
  // Access state machine.
  // ****************************************************************
  reg [2:0] state_q;
  reg [2:0] state_d;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (write_req(pin_sync_q)) begin
          state_d = ST_WRITE;
        end else if (read_req(pin_sync_q)) begin
          state_d = ST_READ;
        end
      end
      ST_READ: begin
        if (!ds_act || !cs_act) begin
          state_d = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (!wr_act || !cs_act) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // Access phase decoding.
  // ****************************************************************
  wire rd_start;
  wire wr_start;
  wire rd_hold;
  wire wr_hold;

  assign rd_start = (state_q == ST_IDLE) && (state_d == ST_READ);
  assign wr_start = (state_q == ST_IDLE) && (state_d == ST_WRITE);
  assign rd_hold = (state_q == ST_READ) && (state_d == ST_READ);
  assign wr_hold = (state_q == ST_WRITE) && (state_d == ST_WRITE);

  // ****************************************************************
  // Register file strobes.
  // ****************************************************************
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      REG_WR <= 1'b0;
      REG_RD <= 1'b0;
      REG_ADDR <= `HRBP_ZERO_ADDR;
      REG_WDATA <= `HRBP_ZERO_DATA;
    end else begin
      REG_RD <= rd_start;
      REG_WR <= wr_start;
      if (rd_start || wr_start) begin
        REG_ADDR <= addr_sync_q;
      end
      if (wr_start) begin
        REG_WDATA <= data_sync_q;
      end
    end
  end

  // ****************************************************************
  // Host data bus.
  // ****************************************************************
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      DATA_OUT <= `HRBP_ZERO_DATA;
      DATA_OE <= 1'b0;
    end else begin
      if (rd_hold) begin
        DATA_OUT <= REG_RDATA;
        DATA_OE <= 1'b1;
      end else begin
        DATA_OE <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Transfer acknowledge.
  // ****************************************************************
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      TRANSFER_ACKNOWLEDGE_LOW <= 1'b1;
      TRANSFER_ACKNOWLEDGE_OE <= 1'b0;
    end else begin
      if (rd_hold || wr_hold) begin
        TRANSFER_ACKNOWLEDGE_LOW <= 1'b0;
        TRANSFER_ACKNOWLEDGE_OE <= 1'b1;
      end else begin
        TRANSFER_ACKNOWLEDGE_LOW <= 1'b1;
        TRANSFER_ACKNOWLEDGE_OE <= 1'b0;
      end
    end
  end

endmodule

// >>> tb/hrbp_reg_model.sv
`timescale 1ns/1ps
// ****
// Register file behind the port.
// ****
module hrbp_reg_model (
  input logic clk, wr,
  input logic [4:0] addr,
  input logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:31];
  always @(posedge clk) if (wr) mem[addr] <= wdata;
  assign rdata = mem[addr];
endmodule

// >>> tb/hrbp_chk_properties.sv
`timescale 1ns/1ps
// ****
// Host port properties.
// ****
module hrbp_chk (
  input logic SYS_CLK, RST_B, CHIP_SELECT_LOW, DATA_OR_READ_STROBE_LOW,
  input logic DIRECTION_OR_WRITE_STROBE_LOW, DATA_OE, TRANSFER_ACKNOWLEDGE_LOW,
  input logic TRANSFER_ACKNOWLEDGE_OE, REG_WR, REG_RD,
  input logic [7:0] DATA_OUT, REG_RDATA
);
  wire cs = CHIP_SELECT_LOW;
  wire ds = DATA_OR_READ_STROBE_LOW;
  wire wr = DIRECTION_OR_WRITE_STROBE_LOW;
  wire ak = TRANSFER_ACKNOWLEDGE_LOW;
  wire ao = TRANSFER_ACKNOWLEDGE_OE;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  sequence s_rd; $fell(ds) ##0 !cs && wr; endsequence
  sequence s_wr; $fell(wr) ##0 !cs; endsequence
  a_rd_start: assert property (s_rd |-> ##[2:4] REG_RD) else $error("no rd");
  a_wr_start: assert property (s_wr |-> ##[2:4] REG_WR) else $error("no wr");
  a_rd_answer: assert property (REG_RD |=> DATA_OE && ao && !ak
    && DATA_OUT == $past(REG_RDATA)) else $error("bad rd");
  a_wr_answer: assert property (REG_WR |=> ao && !ak && !DATA_OE) else $error("bad wr");
  a_ack_hold: assert property (ao && !ak && !(ds && wr) |=> ao && !ak) else $error("drop");
  a_rd_release: assert property ($rose(ds) && DATA_OE |-> ##[1:4] !DATA_OE && !ao)
    else $error("rd held");
  a_wr_release: assert property ($rose(wr) && ao |-> ##[1:4] !ao) else $error("wr held");
  a_cs_ignore: assert property (cs [*4] |-> !ao && !DATA_OE && !REG_RD && !REG_WR)
    else $error("cs off");
  a_sync_lag: assert property ((REG_RD || REG_WR) |-> $past(!cs, 2) && $past(!cs))
    else $error("fast");
endmodule
bind hrbp_host_port hrbp_chk u_chk (.*);

// >>> tb/hrbp_host_port_test.sv
`timescale 1ns/1ps
// ****
// Host port bench.
// ****
module hrbp_host_port_test;
  logic clk = 0, rst_b = 0, cs = 1, ds = 1, wr = 1;
  logic [4:0] addr = 5'h00;
  logic [7:0] din = 8'h00, rd;
  wire [7:0] dout, wdata, rdata;
  wire [4:0] raddr;
  wire doe, ak, aoe, rwr, rrd;
  int fails = 0, n_tests = 0;
  always #10 clk = ~clk;
  hrbp_host_port u_dut (.SYS_CLK(clk), .RST_B(rst_b), .CHIP_SELECT_LOW(cs),
    .DATA_OR_READ_STROBE_LOW(ds), .DIRECTION_OR_WRITE_STROBE_LOW(wr), .ADDR(addr),
    .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe), .TRANSFER_ACKNOWLEDGE_LOW(ak),
    .TRANSFER_ACKNOWLEDGE_OE(aoe), .REG_WR(rwr), .REG_RD(rrd), .REG_ADDR(raddr),
    .REG_WDATA(wdata), .REG_RDATA(rdata));
  hrbp_reg_model u_regs (.clk(clk), .wr(rwr), .addr(raddr), .wdata(wdata), .rdata(rdata));
  task chk(input string n, input logic [7:0] s, e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task bus(input logic w, input logic [4:0] a, input logic [7:0] d, input int hold);
    int i;
    addr = a;
    din = d;
    cs = 0;
    ds = w;
    wr = !w;
    for (i = 0; i < 20 && !(aoe === 1'b1 && ak === 1'b0); i++) step(1);
    rd = dout;
    step(hold);
    chk("ack", {7'h00, aoe === 1'b1 && ak === 1'b0}, 8'h01);
    ds = 1;
    wr = 1;
    din = ~din;
    addr = ~addr;
    for (i = 0; i < 8 && aoe !== 1'b0; i++) step(1);
    chk("release", {6'h00, aoe, doe}, 8'h00);
  endtask
  task t_rw;
    bus(1, 5'h1F, 8'hA5, 0);
    bus(1, 5'h00, 8'h5A, 0);
    bus(0, 5'h1F, 8'h00, 0);
    chk("rd1", rd, 8'hA5);
    bus(0, 5'h00, 8'h00, 0);
    chk("rd0", rd, 8'h5A);
    $display("rw done");
  endtask
  task t_hold;
    bus(0, 5'h1F, 8'h00, 8);
    chk("rdh", rd, 8'hA5);
    $display("hold done");
  endtask
  task t_nocs;
    cs = 1;
    ds = 0;
    step(8);
    chk("nocs", {6'h00, aoe, doe}, 8'h00);
    ds = 1;
    step(4);
    $display("nocs done");
  endtask
  task t_reset;
    cs = 0;
    ds = 1;
    wr = 0;
    addr = 5'h03;
    din = 8'h3C;
    step(6);
    rst_b = 0;
    step(1);
    chk("rst_out", {6'h00, aoe, doe}, 8'h00);
    chk("rst_ack", {7'h00, ak}, 8'h01);
    wr = 1;
    step(5);
    rst_b = 1;
    step(3);
    bus(0, 5'h03, 8'h00, 0);
    chk("rd_rst", rd, 8'h3C);
    $display("reset done");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    step(12);
    rst_b = 1;
    step(3);
    t_rw;
    t_hold;
    t_nocs;
    t_reset;
    finish_test;
  end
  initial begin
    #100000;
    fails++;
    finish_test;
  end
endmodule
